/* File: hdl/processing_error_pkg.sv */
// Constants for the processing error status block: register map,
// bit positions, reset values, configuration limits and timing.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
//
// What this block does
// - Set bit 0 when no trigger arrives during noise measurement.
// - Set bit 1 when noise sample bins lie past the trigger range.
// - Set bit 2 when no trigger arrives during a dwell compute command.
// - Set bit 3 when pulse period drifts over 10 us in one interval.
// - Set bit 5 on internal FIFO overflow during the last dwell command.
// - Command while awaiting output FIFO room: run it, zero lost data, set bit 6.
// - Set bit 7 on an error in the last noise sample command.
// - Set bit 9 when the last bin selection load fails.
// - Set bit 10 when the host breaks the sim data load protocol.
// - Set bit 11 when the measured phase sequence is wrong.
// - Bit 15 flags spectrum size above 128 or below 4.
// - Bit 15 flags over 342 bins per slave in transform modes.
// - Bit 15 flags bins times (sample size plus 4) over 26200 in transform modes.
// - Bit 15 flags bins times sample size over 3000 with series output.
// - Bit 15 flags an odd bin count under fast polarization switching.
// - Bit 15 flags an unsupported polarization parameter combination.

package processing_error_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_PENDING = 4'h8;

    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] VALID_BITS = 16'h8EEF;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int BIT_NOISE_NO_TRIG = 0;
    localparam int BIT_NOISE_FAST = 1;
    localparam int BIT_DWELL_NO_TRIG = 2;
    localparam int BIT_PRT_DRIFT = 3;
    localparam int BIT_FIFO_OVF = 5;
    localparam int BIT_OUT_LOST = 6;
    localparam int BIT_NOISE_ERR = 7;
    localparam int BIT_BIN_LOAD = 9;
    localparam int BIT_SIM_PROTO = 10;
    localparam int BIT_PHASE_SEQ = 11;
    localparam int BIT_BAD_CONFIG = 15;

    // ------------------------------------------------------------
    // Configuration limits
    // ------------------------------------------------------------
    localparam logic [15:0] SPEC_MAX = 16'h0080;
    localparam logic [15:0] SPEC_MIN = 16'h0004;
    localparam logic [15:0] BINS_MAX = 16'h0156;
    localparam logic [16:0] FFT_PAD = 17'h00004;
    localparam logic [33:0] FFT_LIMIT = 34'h000006658;
    localparam logic [33:0] SERIES_LIMIT = 34'h000000BB8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PRT_DRIFT_NS = 10000;
    localparam logic [23:0] PRT_DRIFT_CYC = 24'(PRT_DRIFT_NS / CLK_PERIOD_NS);
    localparam int TRIG_WAIT_NS = 50000000;
    localparam int TRIG_WAIT_CYC = TRIG_WAIT_NS / CLK_PERIOD_NS;

endpackage : processing_error_pkg

/* File: hdl/processing_error_status.sv */
// Processing error status word with sticky bits, mask and interrupt,
// reached over AXI4-Lite.
// Assumes event strobes come from logic on clk_sys; only the trigger
// arrives from a pin and is synchronised here.
`timescale 1ns/1ps
`default_nettype none

module processing_error_status #(
    parameter int TRIG_WAIT_CYCLES = processing_error_pkg::TRIG_WAIT_CYC,
    parameter int CNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trigger pin and processing state
    input wire logic trigger_pin,
    input wire logic noise_active,
    input wire logic dwell_active,
    input wire logic [CNT_W-1:0] noise_bin_end,
    input wire logic [CNT_W-1:0] trigger_range,
    // Pulse period samples, in clk_sys cycles
    input wire logic interval_done,
    input wire logic [23:0] prt_start,
    input wire logic [23:0] prt_end,
    // Command strobes and error events
    input wire logic dwell_compute_command,
    input wire logic noise_sample_command,
    input wire logic bin_selection_load,
    input wire logic fifo_overflow,
    input wire logic cmd_strobe,
    input wire logic out_fifo_wait,
    input wire logic noise_error,
    input wire logic bin_load_error,
    input wire logic sim_data_load_error,
    input wire logic phase_seq_error,
    // Dwell configuration, valid with dwell_compute_command
    input wire logic [CNT_W-1:0] spectrum_size,
    input wire logic [CNT_W-1:0] bins_per_slave,
    input wire logic [CNT_W-1:0] sample_size,
    input wire logic [CNT_W-1:0] bins_selected,
    input wire logic transform_mode,
    input wire logic series_output,
    input wire logic fast_pol_switch,
    input wire logic pol_combo_bad,
    // Outputs
    output logic zero_lost_data,
    output logic irq
);

    localparam int WAIT_W = $clog2(TRIG_WAIT_CYCLES + 1);
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(TRIG_WAIT_CYCLES - 1);

    // ------------------------------------------------------------
    // Helper arithmetic
    // ------------------------------------------------------------

    // Product of two widened operands compared to a limit
    function automatic logic prod_over(
        input logic [16:0] a,
        input logic [16:0] b,
        input logic [33:0] lim
    );
        logic [33:0] p;
        p = 34'(a) * 34'(b);
        return p > lim;
    endfunction : prod_over

    // Magnitude of a difference between two period samples
    function automatic logic [23:0] abs_diff(
        input logic [23:0] a,
        input logic [23:0] b
    );
        return (a > b) ? (a - b) : (b - a);
    endfunction : abs_diff

    // Offsets that answer OKAY; shared by both bus paths
    function automatic logic addr_known(
        input logic [3:0] a
    );
        return (a == processing_error_pkg::ADDR_STATUS)
            || (a == processing_error_pkg::ADDR_MASK)
            || (a == processing_error_pkg::ADDR_PENDING);
    endfunction : addr_known

    // ------------------------------------------------------------
    // Trigger pin synchroniser
    // ------------------------------------------------------------
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_level;

    // First stage feeds only the second, containing metastability
    // Change accepted only once stages two and three agree
    wire trig_stable = (trig_s2 == trig_s3);
    wire trig_rise = trig_stable && trig_s2 && !trig_level;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            trig_level <= 1'b0;
        end else begin
            trig_s1 <= trigger_pin;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            if (trig_stable) begin
                trig_level <= trig_s2;
            end
        end
    end

    // ------------------------------------------------------------
    // Missing trigger watchdog
    // ------------------------------------------------------------
    logic [WAIT_W-1:0] wait_cnt;

    // A trigger in the expiry cycle wins and the flag stays clear
    // Limitation: a pin stuck high reads as no trigger after the span
    // Width follows the span; the default span needs 21 bits
    // Counts only while a trigger is expected; restarts on each trigger
    wire waiting = noise_active || dwell_active;
    wire wait_expired = waiting && !trig_rise && (wait_cnt == WAIT_LAST);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_cnt <= '0;
        end else if (!waiting || trig_rise || wait_expired) begin
            wait_cnt <= '0;
        end else begin
            wait_cnt <= wait_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    wire ev_noise_no_trig = wait_expired && noise_active;
    wire ev_dwell_no_trig = wait_expired && dwell_active;
    // Each term is a one-cycle set request
    // Bins past the range seen at each trigger
    wire ev_noise_fast = noise_active && trig_rise && (noise_bin_end > trigger_range);
    wire ev_prt_drift = interval_done && (abs_diff(prt_start, prt_end) > processing_error_pkg::PRT_DRIFT_CYC);
    wire ev_fifo_ovf = fifo_overflow && dwell_active;
    wire ev_out_lost = cmd_strobe && out_fifo_wait;

    // ------------------------------------------------------------
    // Dwell configuration check
    // ------------------------------------------------------------
    // Products are 34 bits wide, so 16-bit operands never wrap
    wire cfg_spec_bad = (spectrum_size > processing_error_pkg::SPEC_MAX)
        || (spectrum_size < processing_error_pkg::SPEC_MIN);
    wire cfg_bins_bad = transform_mode && (bins_per_slave > processing_error_pkg::BINS_MAX);
    wire cfg_fft_mem = transform_mode && prod_over(17'(bins_per_slave),
        17'(sample_size) + processing_error_pkg::FFT_PAD, processing_error_pkg::FFT_LIMIT);
    wire cfg_series_mem = series_output && prod_over(17'(bins_per_slave),
        17'(sample_size), processing_error_pkg::SERIES_LIMIT);
    wire cfg_odd_bins = fast_pol_switch && bins_selected[0];
    wire cfg_bad = cfg_spec_bad || cfg_bins_bad || cfg_fft_mem
        || cfg_series_mem || cfg_odd_bins || pol_combo_bad;

    // Hardware set terms
    // Reserved positions tied low here and masked again below
    wire [15:0] hw_set = {
        dwell_compute_command && cfg_bad,
        3'b000,
        phase_seq_error,
        sim_data_load_error,
        bin_load_error,
        1'b0,
        noise_error,
        ev_out_lost,
        ev_fifo_ovf,
        1'b0,
        ev_prt_drift,
        ev_dwell_no_trig,
        ev_noise_fast,
        ev_noise_no_trig
    };

    // A set in the restart cycle still lands for the new command
    // Bits that describe only the last command restart with a new one
    logic [15:0] restart;
    always_comb begin
        restart = '0;
        restart[processing_error_pkg::BIT_FIFO_OVF] = dwell_compute_command;
        restart[processing_error_pkg::BIT_BAD_CONFIG] = dwell_compute_command;
        restart[processing_error_pkg::BIT_NOISE_ERR] = noise_sample_command;
        restart[processing_error_pkg::BIT_BIN_LOAD] = bin_selection_load;
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    // One strobe per channel, true at the edge that moves an item
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire b_take = s_axi_bvalid && s_axi_bready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire r_take = s_axi_rvalid && s_axi_rready;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // Both address and data held, response not yet raised
    wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [15:0] wr_bits = wr_data[15:0] & lane_mask;
    wire wr_status = do_write && (wr_addr == processing_error_pkg::ADDR_STATUS);
    wire wr_mask = do_write && (wr_addr == processing_error_pkg::ADDR_MASK);
    // Writes to the pending view answer OKAY but change nothing
    wire wr_known = addr_known(wr_addr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            wr_addr <= 4'h0;
        end else if (aw_take) begin
            s_axi_awready <= 1'b0;
            wr_addr <= {s_axi_awaddr[3:2], 2'b00};
        end else if (b_take) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (w_take) begin
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (b_take) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Unmapped addresses answer DECERR and change nothing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? 2'b00 : 2'b11;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status and mask registers
    // ------------------------------------------------------------
    logic [15:0] status;
    logic [15:0] mask;

    // Set beats a same-cycle clear; undefined bits never stick
    wire [15:0] w1c = wr_status ? wr_bits : 16'h0000;
    wire [15:0] next_status = ((status & ~w1c & ~restart) | hw_set)
        & processing_error_pkg::VALID_BITS;
    wire [15:0] next_mask = (mask & ~lane_mask) | (wr_data[15:0] & lane_mask);
    wire [15:0] pending = status & mask;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status <= processing_error_pkg::STATUS_RST;
            mask <= processing_error_pkg::MASK_RST;
        end else begin
            status <= next_status;
            if (wr_mask) begin
                mask <= next_mask & processing_error_pkg::VALID_BITS;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt and lost data outputs
    // ------------------------------------------------------------
    // Registered so both leave the block straight from flip-flops
    // Interrupt follows next status, so it rises with its bit
    // Level interrupt and one-cycle lost data zeroing pulse
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            zero_lost_data <= 1'b0;
        end else begin
            irq <= |(next_status & (wr_mask ? next_mask : mask));
            zero_lost_data <= ev_out_lost;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
    wire rd_status = rd_addr == processing_error_pkg::ADDR_STATUS;
    wire rd_mask = rd_addr == processing_error_pkg::ADDR_MASK;
    wire rd_pend = rd_addr == processing_error_pkg::ADDR_PENDING;
    wire [15:0] rd_word = rd_status ? status : rd_mask ? mask : rd_pend ? pending : 16'h0000;

    // Shared decode keeps write and read answers in step
    // One read in flight; upper half always reads zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= addr_known(rd_addr) ? 2'b00 : 2'b11;
        end else if (r_take) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : processing_error_status

`default_nettype wire

/* File: test/trig_gen.sv */
// Trigger source standing in for the radar timing side.
// Assumes one clk_sys domain; the pin stays low while disabled.
`timescale 1ns/1ps
`default_nettype none
module trig_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic en,
    output logic trigger_pin
);
    logic [2:0] cnt;
    // Period of 8 cycles, well inside the watchdog span
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            trigger_pin <= 1'b0;
        end else if (!en) begin
            cnt <= 3'h0;
            trigger_pin <= 1'b0;
        end else begin
            cnt <= cnt + 3'h1;
            trigger_pin <= cnt[2];
        end
    end
endmodule : trig_gen
`default_nettype wire

/* File: test/processing_error_chk.sv */
// Port checker for the processing error status block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module processing_error_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic cmd_strobe,
    input wire logic out_fifo_wait,
    input wire logic zero_lost_data,
    input wire logic irq
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    lost_pulse_a: assert property (cmd_strobe && out_fifo_wait |=> zero_lost_data)
        else $error("lost data pulse missing");
    lost_cause_a: assert property (zero_lost_data |-> $past(cmd_strobe && out_fifo_wait))
        else $error("lost data pulse without cause");
    rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
        && s_axi_rdata[14:12] == 3'h0 && !s_axi_rdata[8] && !s_axi_rdata[4]) else $error("reserved bit set");
    wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer open");
    decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    // Main scenarios seen
    cover property (zero_lost_data);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule : processing_error_chk
bind processing_error_status processing_error_chk chk (.*);
`default_nettype wire

/* File: test/processing_error_status_test.sv */
// Self-checking bench for the processing error status block.
// Assumes the trigger source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module processing_error_status_test;
    logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, zero_lost_data, irq;
    logic trigger_pin, nact, dact, tg_en, transform_mode, series_output, fast_pol_switch, pol_combo_bad;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, lf;
    logic [1:0] s_axi_bresp, s_axi_rresp, exp_b;
    logic [1:0] bq[$];
    logic [10:0] evs;
    logic [15:0] noise_bin_end, trigger_range, spectrum_size, bins_per_slave, sample_size, bins_selected;
    logic [23:0] prt_start, prt_end, b;
    logic [33:0] q[$];
    logic [33:0] exp_v;
    int n_fail, n_tests, cyc, i;
    int bp[6] = '{11, 7, 9, 10, 5, 6};
    // ----------------------------------------
    // Design and trigger source
    // ----------------------------------------
    processing_error_status #(.TRIG_WAIT_CYCLES(20)) dut (.*, .noise_active(nact),
        .dwell_active(dact | evs[4]), .interval_done(evs[7]), .dwell_compute_command(evs[6]),
        .noise_sample_command(evs[8]), .bin_selection_load(evs[9]), .fifo_overflow(evs[4] | evs[10]),
        .cmd_strobe(evs[5]), .out_fifo_wait(evs[5]), .noise_error(evs[1]), .bin_load_error(evs[2]),
        .sim_data_load_error(evs[3]), .phase_seq_error(evs[0]));
    trig_gen tg (.clk_sys, .rst_n, .en(tg_en), .trigger_pin);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    task pulse(input logic [10:0] v);
        evs <= v;
        @(posedge clk_sys);
        evs <= 11'h000;
        repeat (2) @(posedge clk_sys);
    endtask : pulse
    // Extra edge at the end so a following task never drives a strobe twice at once
    task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task rd(input logic [3:0] a, input logic [15:0] e, input logic [1:0] r = 2'h0);
        q.push_back({r, 16'h0000, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    task cfg(input logic [15:0] s, w, m, l, input logic [3:0] f, input logic bad);
        spectrum_size <= s;
        bins_per_slave <= w;
        sample_size <= m;
        bins_selected <= l;
        {transform_mode, series_output, fast_pol_switch, pol_combo_bad} <= f;
        pulse(11'h040);
        rd(4'h0, {bad, 15'h0000});
    endtask : cfg
    task drift(input logic [23:0] s, e, input logic [15:0] x);
        prt_start <= s;
        prt_end <= e;
        pulse(11'h080);
        rd(4'h0, x);
        wr(4'h0, 16'hFFFF);
    endtask : drift
    task trg(input logic t, n, d, input logic [15:0] x);
        {tg_en, nact, dact} <= {t, n, d};
        repeat (30) @(posedge clk_sys);
        {tg_en, nact, dact} <= 3'h0;
        repeat (6) @(posedge clk_sys);
        rd(4'h0, x);
        wr(4'h0, 16'hFFFF);
    endtask : trg
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Oldest expected read value meets each answer
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) begin
            exp_v = q.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, exp_v)
        end
        if (s_axi_bvalid && s_axi_bready) begin
            exp_b = bq.pop_front();
            `CHK(s_axi_bresp, exp_b)
        end
    end
    // Hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, nact, dact, tg_en} = 8'h00;
        {transform_mode, series_output, fast_pol_switch, pol_combo_bad} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hF, 32'h0};
        {evs, noise_bin_end, trigger_range, spectrum_size} = {11'h000, 48'h0};
        {bins_per_slave, sample_size, bins_selected, prt_start, prt_end} = {48'h0, 48'h0};
        lf = 32'hFC6E;
        rst_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(4'h0, 16'h0000);
        rd(4'h4, 16'h0000);
        wr(4'h4, 16'hFFFF);
        rd(4'h4, 16'h8EEF);
        pulse(11'h001);
        `CHK(irq, 1'b1)
        rd(4'h8, 16'h0800);
        wr(4'h0, 16'hFFFF);
        `CHK(irq, 1'b0)
        wr(4'h4, 16'h0000);
        rd(4'hC, 16'h0000, 2'h3);
        wr(4'hC, 16'hFFFF, 2'h3);
        // Six strobe event sources on their own, then cleared
        for (i = 0; i < 6; i++) begin
            pulse(11'h001 << i);
            rd(4'h0, 16'h0001 << bp[i]);
            wr(4'h0, 16'hFFFF);
            rd(4'h0, 16'h0000);
        end
        pulse(11'h400);
        rd(4'h0, 16'h0000);
        pulse(11'h002);
        pulse(11'h100);
        rd(4'h0, 16'h0000);
        pulse(11'h004);
        pulse(11'h200);
        rd(4'h0, 16'h0000);
        // Limits tried on both sides of each boundary
        cfg(16'h0003, 16'h0000, 16'h0000, 16'h0000, 4'h0, 1'b1);
        cfg(16'h0081, 16'h0000, 16'h0000, 16'h0000, 4'h0, 1'b1);
        cfg(16'h0080, 16'h0156, 16'h0000, 16'h0000, 4'h8, 1'b0);
        cfg(16'h0008, 16'h0157, 16'h0000, 16'h0000, 4'h8, 1'b1);
        cfg(16'h0008, 16'h0064, 16'h0102, 16'h0000, 4'h8, 1'b0);
        cfg(16'h0008, 16'h0064, 16'h0103, 16'h0000, 4'h8, 1'b1);
        cfg(16'h0008, 16'h0064, 16'h001E, 16'h0000, 4'h4, 1'b0);
        cfg(16'h0008, 16'h0064, 16'h001F, 16'h0000, 4'h4, 1'b1);
        cfg(16'h0008, 16'h0000, 16'h0000, 16'h0005, 4'h2, 1'b1);
        cfg(16'h0008, 16'h0000, 16'h0000, 16'h0004, 4'h2, 1'b0);
        cfg(16'h0008, 16'h0000, 16'h0000, 16'h0000, 4'h1, 1'b1);
        cfg(16'h0004, 16'h0000, 16'h0000, 16'h0000, 4'h0, 1'b0);
        pulse(11'h010);
        pulse(11'h040);
        rd(4'h0, 16'h0000);
        lf = lfsr(lf);
        b = {8'h00, lf[15:0]} + 24'h000400;
        drift(b, b + 24'h000190, 16'h0000);
        drift(b, b + 24'h000191, 16'h0008);
        drift(b + 24'h000191, b, 16'h0008);
        noise_bin_end <= 16'h000A;
        trigger_range <= 16'h0009;
        trg(1'b1, 1'b1, 1'b0, 16'h0002);
        noise_bin_end <= 16'h0009;
        trg(1'b1, 1'b1, 1'b0, 16'h0000);
        trg(1'b0, 1'b1, 1'b0, 16'h0001);
        trg(1'b0, 1'b0, 1'b1, 16'h0004);
        trg(1'b1, 1'b0, 1'b1, 16'h0000);
        conclude();
    end
endmodule : processing_error_status_test
`default_nettype wire
